// ### rtl/rpsc_pkg.sv
// package: constants for the reset pin state controller
package rpsc_pkg;
   localparam int RPSC_DATA_W = 16;
   localparam int RPSC_CS_W = 11;
   localparam int RPSC_ADDR_HI_W = 4;
   localparam int RPSC_PWM_W = 4;
   // mode-select bit positions on the data bus
   localparam int RPSC_MS_BOOT8 = 0;
   localparam int RPSC_MS_BUSARB = 1;
   localparam int RPSC_MS_FCODE = 2;
   localparam int RPSC_MS_ADDR_LO = 3;
   localparam int RPSC_MS_ADDR_HI = 6;
   localparam int RPSC_MS_PORTE = 8;
   localparam int RPSC_MS_PORTF = 9;
   // reset values
   localparam logic RPSC_CS_IDLE = 1'b1;
   localparam logic RPSC_STROBE_IDLE = 1'b1;
   localparam logic [RPSC_PWM_W-1:0] RPSC_PWM_RST = 4'h0;
   localparam logic [RPSC_DATA_W-1:0] RPSC_MODE_RST = 16'hffff;
   // first bus cycle starts this many clk_sys cycles after release
   localparam int RPSC_FIRST_BUS_CYC = 10;
   localparam logic [3:0] RPSC_FIRST_BUS_CNT = 4'(RPSC_FIRST_BUS_CYC);
   typedef enum logic [1:0] {
      RPSC_IN_RESET = 2'b00,
      RPSC_LATCH = 2'b01,
      RPSC_WAIT_BUS = 2'b11,
      RPSC_RUN = 2'b10
   } rpsc_phase_e;
endpackage

// ### rtl/rpsc_sync2.sv
// two-flop synchroniser, one instance per bus, W bits wide
`timescale 1ns/1ps
module rpsc_sync2 #(
   parameter int W = 1
) (
   input wire logic clk_sys,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   // no reset: pin levels must ride through while reset is held, else the latch sees idle values
   logic [W-1:0] meta_q;
   always_ff @(posedge clk_sys) begin
      meta_q <= d;
      q <= meta_q;
   end
endmodule

// ### rtl/rpsc_top.sv
// reset pin state controller: pin function and driver state around reset
`timescale 1ns/1ps
module rpsc_top
   import rpsc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic [RPSC_DATA_W-1:0] data_bus_in,
   input wire logic clock_source_select,
   input wire logic test_or_tristate_pin,
   input wire logic breakpoint_debug_clock,
   // functional values from the bus engine, used only once running
   input wire logic [RPSC_CS_W-1:0] cs_func_n,
   input wire logic bus_func_strobes_n,
   input wire logic bus_func_rw,
   input wire logic [RPSC_PWM_W-1:0] pwm_func,
   // pin function selection
   output logic boot_mem_select,
   output logic boot_port_8bit,
   output logic [RPSC_CS_W-1:0] cs_n_out,
   output logic [RPSC_CS_W-1:0] cs_n_oe,
   output logic busarb_mode,
   output logic fcode_mode,
   output logic [RPSC_ADDR_HI_W:0] addr_hi_mode,
   output logic port_e_line,
   output logic port_f_line,
   output logic clock_from_ext,
   output logic debug_enabled,
   output logic address_strobe_n,
   output logic data_strobe_n,
   output logic locked_cycle_n,
   output logic strobe_oe,
   output logic read_write,
   output logic read_write_oe,
   output logic data_bus_oe,
   output logic handshake_oe,
   output logic reset_pin_oe,
   output logic system_clock_out,
   output logic [RPSC_PWM_W-1:0] timer_pwm_out,
   output logic [RPSC_PWM_W-1:0] timer_pwm_oe,
   output logic periph_port_func_en,
   output logic periph_dir_out,
   output logic exception_start
);
   logic [RPSC_DATA_W-1:0] data_s;
   logic clksel_s;
   logic bkpt_s;
   rpsc_phase_e phase_q;
   logic [3:0] bus_cnt_q;
   logic [RPSC_DATA_W-1:0] mode_q;
   logic clkmode_q;
   logic bkpt_q;
   logic clk_div_q;
   logic running;

   rpsc_sync2 #(.W(RPSC_DATA_W)) u_sync_data (
      .clk_sys(clk_sys),
      .d(data_bus_in),
      .q(data_s)
   );
   rpsc_sync2 #(.W(2)) u_sync_misc (
      .clk_sys(clk_sys),
      .d({clock_source_select, breakpoint_debug_clock}),
      .q({clksel_s, bkpt_s})
   );

   assign running = (phase_q == RPSC_RUN);

   // reset phase sequencing
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         phase_q <= RPSC_IN_RESET;
         bus_cnt_q <= 4'h0;
      end else begin
         unique case (phase_q)
            RPSC_IN_RESET: begin
               phase_q <= RPSC_LATCH;
            end
            RPSC_LATCH: begin
               phase_q <= RPSC_WAIT_BUS;
               bus_cnt_q <= 4'h1;
            end
            RPSC_WAIT_BUS: begin
               // data bus left to mode drivers until the first bus cycle
               if (bus_cnt_q >= RPSC_FIRST_BUS_CNT - 4'h1) begin
                  phase_q <= RPSC_RUN;
               end
               bus_cnt_q <= bus_cnt_q + 4'h1;
            end
            RPSC_RUN: begin
               phase_q <= RPSC_RUN;
            end
         endcase
      end
   end

   // mode latch: captured once, in the first cycle after release
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         mode_q <= RPSC_MODE_RST;
         clkmode_q <= 1'b1;
         bkpt_q <= 1'b1;
      end else if (phase_q == RPSC_IN_RESET) begin
         mode_q <= data_s;
         clkmode_q <= clksel_s;
         bkpt_q <= bkpt_s;
      end
   end

   // pin functions from latched modes
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         boot_port_8bit <= 1'b0;
         busarb_mode <= 1'b0;
         fcode_mode <= 1'b0;
         addr_hi_mode <= '0;
         port_e_line <= 1'b0;
         port_f_line <= 1'b0;
         clock_from_ext <= 1'b0;
         debug_enabled <= 1'b0;
      end else if (phase_q == RPSC_LATCH) begin
         boot_port_8bit <= ~mode_q[RPSC_MS_BOOT8];
         busarb_mode <= ~mode_q[RPSC_MS_BUSARB];
         fcode_mode <= ~mode_q[RPSC_MS_FCODE];
         addr_hi_mode <= ~mode_q[RPSC_MS_ADDR_HI+1:RPSC_MS_ADDR_LO];
         port_e_line <= ~mode_q[RPSC_MS_PORTE];
         port_f_line <= ~mode_q[RPSC_MS_PORTF];
         clock_from_ext <= ~clkmode_q;
         debug_enabled <= ~bkpt_q;
      end
   end

   // chip selects: idle high in reset and until running; every line always driven
   genvar gi;
   generate
      for (gi = 0; gi < RPSC_CS_W; gi++) begin : g_cs
         always_ff @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
               cs_n_out[gi] <= RPSC_CS_IDLE;
               cs_n_oe[gi] <= 1'b1;
            end else begin
               cs_n_out[gi] <= running ? cs_func_n[gi] : RPSC_CS_IDLE;
               cs_n_oe[gi] <= 1'b1;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         boot_mem_select <= 1'b1;
      end else begin
         boot_mem_select <= 1'b0;
      end
   end

   // bus control pins
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         address_strobe_n <= RPSC_STROBE_IDLE;
         data_strobe_n <= RPSC_STROBE_IDLE;
         locked_cycle_n <= RPSC_STROBE_IDLE;
         strobe_oe <= 1'b0;
         read_write <= 1'b1;
         read_write_oe <= 1'b0;
         data_bus_oe <= 1'b0;
         handshake_oe <= 1'b0;
         reset_pin_oe <= 1'b0;
      end else begin
         address_strobe_n <= running ? bus_func_strobes_n : RPSC_STROBE_IDLE;
         data_strobe_n <= running ? bus_func_strobes_n : RPSC_STROBE_IDLE;
         locked_cycle_n <= RPSC_STROBE_IDLE;
         // from the latched pin, so port E strobes never see a one-cycle drive
         strobe_oe <= (phase_q != RPSC_IN_RESET) && mode_q[RPSC_MS_PORTE];
         read_write <= running ? bus_func_rw : 1'b1;
         read_write_oe <= (phase_q != RPSC_IN_RESET);
         data_bus_oe <= 1'b0;
         handshake_oe <= 1'b0;
         reset_pin_oe <= 1'b0;
      end
   end

   // clock output toggles every clk_sys cycle, held low during reset
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         clk_div_q <= 1'b0;
      end else begin
         clk_div_q <= ~clk_div_q;
      end
   end
   assign system_clock_out = clk_div_q;

   // peripheral pins: port functions, directions cleared
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         periph_port_func_en <= 1'b0;
         periph_dir_out <= 1'b0;
         timer_pwm_out <= RPSC_PWM_RST;
         timer_pwm_oe <= '0;
         exception_start <= 1'b0;
      end else begin
         periph_port_func_en <= 1'b0;
         periph_dir_out <= 1'b0;
         timer_pwm_out <= running ? pwm_func : RPSC_PWM_RST;
         timer_pwm_oe <= {RPSC_PWM_W{running}};
         exception_start <= (phase_q == RPSC_LATCH);
      end
   end
endmodule

// ### tb/rpsc_board.sv
// board model: mode-select drivers and data-line pull-ups
`timescale 1ns/1ps
module rpsc_board
   import rpsc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic [RPSC_DATA_W-1:0] mode_word,
   input wire logic mode_clk,
   input wire logic mode_bkpt,
   output logic [RPSC_DATA_W-1:0] data_bus_in,
   output logic clock_source_select,
   output logic breakpoint_debug_clock
);
   logic [3:0] hold_q;
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) hold_q <= 4'h0;
      else if (hold_q != 4'hf) hold_q <= hold_q + 4'h1;
   end
   // held a little past release for the synchroniser, well before the first bus cycle
   wire drive = !rst_b || hold_q < 4'h3;
   assign data_bus_in = drive ? mode_word : 16'hffff;
   assign clock_source_select = drive ? mode_clk : 1'h1;
   assign breakpoint_debug_clock = drive ? mode_bkpt : 1'h1;
endmodule

// ### tb/rpsc_top_sva.sv
// checker: pin driver states around reset release
`timescale 1ns/1ps
module rpsc_top_sva
   import rpsc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic [RPSC_CS_W-1:0] cs_func_n,
   input wire logic boot_mem_select,
   input wire logic [RPSC_CS_W-1:0] cs_n_out,
   input wire logic [RPSC_CS_W-1:0] cs_n_oe,
   input wire logic port_e_line,
   input wire logic strobe_oe,
   input wire logic read_write_oe,
   input wire logic data_bus_oe,
   input wire logic handshake_oe,
   input wire logic reset_pin_oe,
   input wire logic periph_port_func_en,
   input wire logic periph_dir_out,
   input wire logic system_clock_out,
   input wire logic [RPSC_PWM_W-1:0] timer_pwm_out,
   input wire logic exception_start
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   sequence s_release;
      $rose(rst_b);
   endsequence
   // pulse only after the modes have had two edges to latch
   sequence s_exc_once;
      !exception_start [*2] ##1 exception_start ##1 !exception_start;
   endsequence
   AST_RST_PINS: assert property (
      s_release |-> boot_mem_select && &cs_n_out && !strobe_oe && !read_write_oe)
      else $error("pin not idle while in reset");
   AST_BOOT_LOW: assert property (s_release |=> !boot_mem_select)
      else $error("boot select not active after release");
   AST_EXC_ORDER: assert property (s_release |-> s_exc_once)
      else $error("exception start out of order");
   AST_CS_OE: assert property (&cs_n_oe)
      else $error("chip select driver off");
   AST_INPUTS: assert property (
      !(data_bus_oe || handshake_oe || reset_pin_oe || periph_port_func_en || periph_dir_out))
      else $error("input pin driven");
   AST_PWM_HOLD: assert property (exception_start |-> timer_pwm_out == RPSC_PWM_RST)
      else $error("pwm active before running");
   AST_STROBE_OE: assert property (
      s_release |-> ##2 (strobe_oe == !port_e_line) && read_write_oe)
      else $error("strobe driver state wrong");
   AST_RUN_CS: assert property (s_release ##20 1 |-> cs_n_out == $past(cs_func_n))
      else $error("chip selects not following");
   AST_CLK_RUN: assert property (
      !$rose(rst_b) |-> system_clock_out != $past(system_clock_out))
      else $error("clock output stalled");
endmodule
bind rpsc_top rpsc_top_sva u_sva (.*);

// ### tb/tb.sv
// testbench: mode latch and pin states across reset
`timescale 1ns/1ps
module tb;
   import rpsc_pkg::*;
   logic clk_sys, rst_b, mclk, mbk, strb, rw, csel, bkd;
   logic boot, b8, arb, fc, pe, pf, cx, dbg, as_n, ds_n, soe, rwo, lck;
   logic [RPSC_PWM_W-1:0] pwm_oe;
   logic [RPSC_DATA_W-1:0] mode, dbus;
   logic [RPSC_CS_W-1:0] csf, cs_n_out;
   logic [RPSC_PWM_W-1:0] pwmf, pwm_o;
   logic [RPSC_ADDR_HI_W:0] ahi;
   int error_cnt = 0;
   int num_checks = 0;
   rpsc_board board (.clk_sys, .rst_b, .mode_word(mode), .mode_clk(mclk), .mode_bkpt(mbk),
      .data_bus_in(dbus), .clock_source_select(csel), .breakpoint_debug_clock(bkd));
   rpsc_top dut (.clk_sys, .rst_b, .data_bus_in(dbus), .clock_source_select(csel),
      .test_or_tristate_pin(1'h1), .breakpoint_debug_clock(bkd), .cs_func_n(csf),
      .bus_func_strobes_n(strb), .bus_func_rw(rw), .pwm_func(pwmf), .boot_mem_select(boot),
      .boot_port_8bit(b8), .cs_n_out, .cs_n_oe(), .busarb_mode(arb), .fcode_mode(fc),
      .addr_hi_mode(ahi), .port_e_line(pe), .port_f_line(pf), .clock_from_ext(cx),
      .debug_enabled(dbg), .address_strobe_n(as_n), .data_strobe_n(ds_n), .locked_cycle_n(lck),
      .strobe_oe(soe), .read_write(rwo), .read_write_oe(), .data_bus_oe(), .handshake_oe(),
      .reset_pin_oe(), .system_clock_out(), .timer_pwm_out(pwm_o), .timer_pwm_oe(pwm_oe),
      .periph_port_func_en(), .periph_dir_out(), .exception_start());
   initial begin
      clk_sys = 1'h0;
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic run_mode(logic [15:0] m, logic mc, logic bk);
      @(posedge clk_sys);
      rst_b <= 1'h0;
      mode <= m;
      mclk <= mc;
      mbk <= bk;
      csf <= ~m[10:0];
      pwmf <= m[3:0];
      strb <= m[4];
      rw <= m[5];
      repeat (3) @(posedge clk_sys);
      #1;
      chk("in_reset", 16'({boot, soe, as_n, ds_n, pwm_o}), 16'h00b0);
      chk("cs_reset", 16'(cs_n_out), 16'h07ff);
      chk("bus_reset", 16'({rwo, lck, pwm_oe}), 16'h0030);
      @(posedge clk_sys);
      rst_b <= 1'h1;
      @(posedge clk_sys);
      #1;
      chk("boot_sel", 16'(boot), 16'h0000);
      // board lines go back on pull-ups during this wait, so latched modes must not move
      repeat (20) @(posedge clk_sys);
      #1;
      chk("modes", 16'({b8, arb, fc, pe, pf, cx, dbg, ahi}),
         16'({~m[0], ~m[1], ~m[2], ~m[8], ~m[9], ~mc, ~bk, ~m[7:3]}));
      chk("running", 16'({cs_n_out, pwm_o}), 16'({~m[10:0], m[3:0]}));
      chk("strobes", 16'({soe, as_n, ds_n}), 16'({m[8], m[4], m[4]}));
      chk("bus_run", 16'({rwo, lck, pwm_oe}), 16'({m[5], 1'b1, 4'hf}));
   endtask
   task automatic t_default(); run_mode(16'hffff, 1'h1, 1'h1); endtask
   task automatic t_all_alt(); run_mode(16'hfc00, 1'h0, 1'h0); endtask
   task automatic t_one_addr(); run_mode(16'hffdf, 1'h1, 1'h0); endtask
   task automatic t_port_e(); run_mode(16'hfeff, 1'h0, 1'h1); endtask
   initial begin
      rst_b = 1'h0;
      mode = 16'hffff;
      mclk = 1'h1;
      mbk = 1'h1;
      csf = '1;
      pwmf = '0;
      strb = 1'h1;
      rw = 1'h1;
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'h1;
      t_default();
      t_all_alt();
      t_one_addr();
      t_port_e();
      final_report();
   end
   initial begin
      repeat (1000) @(posedge clk_sys);
      error_cnt++;
      final_report();
   end
endmodule
